// >>> verilog/dwcs_write_collision.sv
// Write-collision detection, fault request, debug status and power gating
// for an eight-channel transfer_controller sharing dual_port_ram with a CPU.
// Assumes all inputs come from logic on ref_clk; no pin synchronisers here.
`timescale 1ns/10ps
module dwcs_write_collision #(
  parameter int unsigned NUM_CHAN = dwcs_pkg::NumChan
) (
  input  wire logic                        ref_clk,
  input  wire logic                        arst_n,
  // CPU side of the shared write path
  input  wire logic                        cpuWrEn,
  input  wire logic                        cpuRdEn,
  input  wire logic                        cpuIsPeriph,
  input  wire logic [dwcs_pkg::AddrW-1:0]  cpuAddr,
  input  wire logic [dwcs_pkg::DataW-1:0]  cpuWrData,
  // Channel side of the shared write path
  input  wire logic                        dmaWrEn,
  input  wire logic                        dmaRdEn,
  input  wire logic                        dmaIsPeriph,
  input  wire logic [dwcs_pkg::ChanIdxW-1:0] dmaChan,
  input  wire logic [dwcs_pkg::AddrW-1:0]  dmaAddr,
  input  wire logic [dwcs_pkg::DataW-1:0]  dmaWrData,
  // Storage write strobes after priority
  output logic                             stCpuWrEn,
  output logic                             stDmaWrEn,
  output logic [dwcs_pkg::AddrW-1:0]       stCpuAddr,
  output logic [dwcs_pkg::AddrW-1:0]       stDmaAddr,
  output logic [dwcs_pkg::DataW-1:0]       stCpuData,
  output logic [dwcs_pkg::DataW-1:0]       stDmaData,
  // Error status
  input  wire logic                        errStatusClear,
  input  wire logic [NUM_CHAN-1:0]         manualTrigErr,
  output logic [dwcs_pkg::StatusW-1:0]     controller_status_zero,
  output logic                             faultTrapReq,
  // Request gating and power modes
  input  wire logic [NUM_CHAN-1:0]         chanReqIn,
  input  wire logic                        sleepMode,
  input  wire logic                        idleMode,
  input  wire logic [NUM_CHAN-1:0]         periphStopInIdle,
  output logic [NUM_CHAN-1:0]              chanReqOut,
  // Audio request fan-out
  input  wire logic                        audioReq,
  input  wire logic [dwcs_pkg::BufLenW-1:0] audio_buffer_length,
  input  wire logic [dwcs_pkg::ChanIdxW-1:0] audioChanZero,
  input  wire logic [dwcs_pkg::ChanIdxW-1:0] audioChanOne,
  output logic [NUM_CHAN-1:0]              audioRxBufSel,
  // Block completion
  input  wire logic [NUM_CHAN-1:0]         blockDone,
  input  wire logic [NUM_CHAN-1:0]         blockIntEn,
  output logic [NUM_CHAN-1:0]              chanIrq,
  output logic                             cpuWake,
  // Debug status
  input  wire logic                        xferDone,
  input  wire logic [dwcs_pkg::ChanIdxW-1:0] xferChan,
  input  wire logic [dwcs_pkg::AddrW-1:0]  xferOffset,
  input  wire logic                        xferBufOne,
  output logic [dwcs_pkg::LastChanW-1:0]   last_channel_field,
  output logic [dwcs_pkg::AddrW-1:0]       last_ram_offset,
  output logic [NUM_CHAN-1:0]              pingpong_buffer_flag
);

  // Status layout packs eight channels per half-word
  if (NUM_CHAN != dwcs_pkg::NumChan) begin
    $error("dwcs_write_collision: NUM_CHAN must be 8");
  end

  logic [NUM_CHAN-1:0]          ramCol_q, ramCol_d;
  logic [NUM_CHAN-1:0]          perCol_q, perCol_d;
  logic [NUM_CHAN-1:0]          colHit;
  logic                         sameAddrWr;
  logic [NUM_CHAN-1:0]          blocked;
  logic [NUM_CHAN-1:0]          audioFan;
  logic [NUM_CHAN-1:0]          reqMerged;
  logic                         xferAllowed;
  logic                         stCpuWrEn_d, stDmaWrEn_d;
  logic [dwcs_pkg::AddrW-1:0]   stCpuAddr_d, stDmaAddr_d;
  logic [dwcs_pkg::DataW-1:0]   stCpuData_d, stDmaData_d;
  logic [NUM_CHAN-1:0]          chanIrq_q, chanIrq_d;
  logic [NUM_CHAN-1:0]          audioSel_q, audioSel_d;
  logic [dwcs_pkg::LastChanW-1:0] lastChan_q, lastChan_d;
  logic [dwcs_pkg::AddrW-1:0]   lastOff_q, lastOff_d;
  logic [NUM_CHAN-1:0]          pingPong_q, pingPong_d;

  // Only write against write counts; reads never enter the compare
  always_comb begin
    sameAddrWr = cpuWrEn && dmaWrEn && (cpuIsPeriph == dmaIsPeriph)
                 && (cpuAddr == dmaAddr);
    colHit     = '0;
    if (sameAddrWr) begin
      colHit[dmaChan] = 1'b1;
    end
  end

  // Storage strobes; both ports latch so reads in the same cycle see old data
  always_comb begin
    stCpuWrEn_d = cpuWrEn;
    stCpuAddr_d = cpuAddr;
    stCpuData_d = cpuWrData;
    stDmaWrEn_d = dmaWrEn && !sameAddrWr;
    stDmaAddr_d = dmaAddr;
    stDmaData_d = dmaWrData;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stCpuWrEn <= 1'b0;
      stDmaWrEn <= 1'b0;
      stCpuAddr <= dwcs_pkg::OffsetReset;
      stDmaAddr <= dwcs_pkg::OffsetReset;
      stCpuData <= dwcs_pkg::OffsetReset;
      stDmaData <= dwcs_pkg::OffsetReset;
    end else begin
      stCpuWrEn <= stCpuWrEn_d;
      stDmaWrEn <= stDmaWrEn_d;
      stCpuAddr <= stCpuAddr_d;
      stDmaAddr <= stDmaAddr_d;
      stCpuData <= stCpuData_d;
      stDmaData <= stDmaData_d;
    end
  end

  // Collision flags; a new event in the clear cycle survives the clear
  always_comb begin
    ramCol_d = ramCol_q;
    perCol_d = perCol_q;
    if (errStatusClear) begin
      ramCol_d = '0;
      perCol_d = '0;
    end
    if (!dmaIsPeriph) begin
      ramCol_d = ramCol_d | colHit;
    end else begin
      perCol_d = perCol_d | colHit;
    end
    // Both flags together mark a manual trigger error
    ramCol_d = ramCol_d | manualTrigErr;
    perCol_d = perCol_d | manualTrigErr;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ramCol_q <= dwcs_pkg::FlagsReset;
      perCol_q <= dwcs_pkg::FlagsReset;
    end else begin
      ramCol_q <= ramCol_d;
      perCol_q <= perCol_d;
    end
  end

  // Status word: RAM flags low byte, peripheral flags high byte
  always_comb begin
    controller_status_zero = '0;
    controller_status_zero[dwcs_pkg::RamColLsb +: NUM_CHAN]    = ramCol_q;
    controller_status_zero[dwcs_pkg::PeriphColLsb +: NUM_CHAN] = perCol_q;
    faultTrapReq = |{ramCol_q, perCol_q};
  end

  // Audio fan-out; pair mode drives both channels from one request
  always_comb begin
    audioFan   = '0;
    audioSel_d = audioSel_q;
    if (audioReq) begin
      audioFan[audioChanZero] = 1'b1;
      if (audio_buffer_length == dwcs_pkg::AudioLenPair) begin
        audioFan[audioChanOne] = 1'b1;
      end
    end
    if (audio_buffer_length == dwcs_pkg::AudioLenPair) begin
      audioSel_d                = '0;
      audioSel_d[audioChanOne]  = 1'b1;
      audioSel_d[audioChanZero] = 1'b0;
    end else begin
      audioSel_d = '0;
    end
  end

  // Request gating: faulted channels, sleep and stop-in-idle peripherals
  always_comb begin
    reqMerged  = chanReqIn | audioFan;
    blocked    = ramCol_q | perCol_q;
    // Idle alone does not stop a channel; only its stopped peripheral does
    if (idleMode) begin
      blocked = blocked | periphStopInIdle;
    end
    // Sleep halts every channel request; a block in flight simply pauses
    chanReqOut = sleepMode ? '0 : (reqMerged & ~blocked);
  end

  // Block interrupts outside sleep drive cpuWake; sleepMode masks both
  always_comb begin
    chanIrq_d = blockDone & blockIntEn & {NUM_CHAN{!sleepMode}};
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      chanIrq_q  <= dwcs_pkg::FlagsReset;
      audioSel_q <= dwcs_pkg::FlagsReset;
    end else begin
      chanIrq_q  <= chanIrq_d;
      audioSel_q <= audioSel_d;
    end
  end

  assign chanIrq       = chanIrq_q;
  assign cpuWake       = |chanIrq_q;
  assign audioRxBufSel = audioSel_q;

  // Debug status follows each completed transfer outside sleep
  always_comb begin
    xferAllowed = xferDone && !sleepMode;
    lastChan_d  = lastChan_q;
    lastOff_d   = lastOff_q;
    pingPong_d  = pingPong_q;
    if (xferAllowed) begin
      lastChan_d           = {1'b0, xferChan};
      lastOff_d            = xferOffset;
      pingPong_d[xferChan] = xferBufOne;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lastChan_q <= dwcs_pkg::LastChanReset;
      lastOff_q  <= dwcs_pkg::OffsetReset;
      pingPong_q <= dwcs_pkg::PingPongReset;
    end else begin
      lastChan_q <= lastChan_d;
      lastOff_q  <= lastOff_d;
      pingPong_q <= pingPong_d;
    end
  end

  assign last_channel_field   = lastChan_q;
  assign last_ram_offset      = lastOff_q;
  assign pingpong_buffer_flag = pingPong_q;

endmodule

// >>> verilog/dwcs_pkg.sv
// Constants shared by the write-collision and status block.
// Assumes one system clock; all users reference names as dwcs_pkg::name.
package dwcs_pkg;
  // Channel count and field widths
  localparam int unsigned NumChan    = 8;
  localparam int unsigned ChanIdxW   = 3;
  localparam int unsigned LastChanW  = 4;
  localparam int unsigned AddrW      = 16;
  localparam int unsigned DataW      = 16;
  localparam int unsigned StatusW    = 16;
  localparam int unsigned BufLenW    = 2;

  // Field positions in controller_status_zero
  localparam int unsigned RamColLsb    = 0;
  localparam int unsigned PeriphColLsb = 8;

  // Audio buffer-length code that splits requests over two channels
  localparam logic [1:0] AudioLenPair = 2'h1;

  // Reset values
  localparam logic [7:0]  FlagsReset    = 8'h00;
  localparam logic [3:0]  LastChanReset = 4'h0;
  localparam logic [15:0] OffsetReset   = 16'h0000;
  localparam logic [7:0]  PingPongReset = 8'h00;
endpackage

// >>> verif/dwcs_monitor.sv
// Checker for collision flags, fault request and request gating.
// Assumes one ref_clk domain, arst_n active low, bound to the block top.
`timescale 1ns/10ps
module dwcs_monitor #(
  parameter int unsigned NUM_CHAN = 8
) (
  input wire logic                  ref_clk,
  input wire logic                  arst_n,
  input wire logic                  cpuWrEn,
  input wire logic                  cpuIsPeriph,
  input wire logic [15:0]           cpuAddr,
  input wire logic [15:0]           cpuWrData,
  input wire logic                  dmaWrEn,
  input wire logic                  dmaIsPeriph,
  input wire logic [2:0]            dmaChan,
  input wire logic [15:0]           dmaAddr,
  input wire logic                  stCpuWrEn,
  input wire logic                  stDmaWrEn,
  input wire logic [15:0]           stCpuData,
  input wire logic                  errStatusClear,
  input wire logic [NUM_CHAN-1:0]   manualTrigErr,
  input wire logic [15:0]           controller_status_zero,
  input wire logic                  faultTrapReq,
  input wire logic [NUM_CHAN-1:0]   chanReqOut,
  input wire logic                  sleepMode
);
  logic coll;
  logic bothWr;
  // Same address and space; sleep excluded since no bench traffic runs then
  assign coll = bothWr && (cpuAddr == dmaAddr) && (cpuIsPeriph == dmaIsPeriph) && !sleepMode;
  assign bothWr = cpuWrEn && dmaWrEn;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  AST_TRAP: assert property (coll |=> faultTrapReq)
    else $error("collision gave no trap");
  AST_PRIO: assert property (
    coll |=> stCpuWrEn && !stDmaWrEn && stCpuData == $past(cpuWrData))
    else $error("cpu write lost priority");
  AST_RAMFLAG: assert property (
    coll && !cpuIsPeriph |=> controller_status_zero[$past(dmaChan)])
    else $error("ram flag not set");
  AST_PERFLAG: assert property (
    coll && cpuIsPeriph |=> controller_status_zero[8 + $past(dmaChan)])
    else $error("periph flag not set");
  // Reads and single-side writes leave clean flags clean
  AST_READ: assert property (
    !bothWr && manualTrigErr == '0 && controller_status_zero == 16'h0000
      |=> controller_status_zero == 16'h0000)
    else $error("flag set without collision");
  AST_OR: assert property (faultTrapReq == (|controller_status_zero))
    else $error("trap is not the flag or");
  AST_CLEAR: assert property (
    errStatusClear && !bothWr && manualTrigErr == '0 |=> controller_status_zero == 16'h0000)
    else $error("flags not cleared");
  AST_GATE: assert property (
    (chanReqOut & (controller_status_zero[7:0] | controller_status_zero[15:8])) == '0)
    else $error("flagged channel not gated");
  AST_MANUAL: assert property (
    manualTrigErr != '0 |=> (controller_status_zero[15:8] & controller_status_zero[7:0]
      & $past(manualTrigErr)) == $past(manualTrigErr))
    else $error("manual error flags wrong");
  AST_SLEEP: assert property (sleepMode |-> chanReqOut == '0)
    else $error("request passed in sleep");
endmodule
bind dwcs_write_collision dwcs_monitor #(.NUM_CHAN(NUM_CHAN)) mon (
  .ref_clk, .arst_n, .cpuWrEn, .cpuIsPeriph, .cpuAddr, .cpuWrData, .dmaWrEn, .dmaIsPeriph,
  .dmaChan, .dmaAddr, .stCpuWrEn, .stDmaWrEn, .stCpuData, .errStatusClear, .manualTrigErr,
  .controller_status_zero, .faultTrapReq, .chanReqOut, .sleepMode
);

// >>> verif/dwcs_ram_model.sv
// Storage behind the shared write path.
// Assumes the block's registered write strobes on ref_clk.
`timescale 1ns/10ps
module dwcs_ram_model (
  input wire logic        ref_clk,
  input wire logic        cpuWe,
  input wire logic [15:0] cpuAddr,
  input wire logic [15:0] cpuData,
  input wire logic        dmaWe,
  input wire logic [15:0] dmaAddr,
  input wire logic [15:0] dmaData,
  input wire logic [15:0] rdAddr,
  output logic     [15:0] rdData
);
  logic [15:0] mem [16];
  // Channel write lands last, so a leaked colliding write would win
  always_ff @(posedge ref_clk) begin
    if (cpuWe) mem[cpuAddr[3:0]] <= cpuData;
    if (dmaWe) mem[dmaAddr[3:0]] <= dmaData;
  end
  assign rdData = mem[rdAddr[3:0]]; // Old word until the edge
endmodule

// >>> verif/dma_write_collision_status_tb.sv
// Directed bench for the write-collision and status block.
// Assumes 200 MHz ref_clk; inputs change on the falling edge.
`timescale 1ns/10ps
module dma_write_collision_status_tb;
  logic ref_clk = 0, arst_n = 0, cpuWrEn = 0, cpuRdEn = 0, cpuIsPeriph = 0, dmaWrEn = 0;
  logic dmaRdEn = 0, dmaIsPeriph = 0, errStatusClear = 0, sleepMode = 0, idleMode = 0;
  logic audioReq = 0, xferDone = 0, xferBufOne = 0, stCpuWrEn, stDmaWrEn, faultTrapReq, cpuWake;
  logic [2:0] dmaChan = 0, audioChanZero = 0, audioChanOne = 0, xferChan = 0;
  logic [1:0] audio_buffer_length = 0;
  logic [3:0] last_channel_field;
  logic [15:0] cpuAddr = 0, cpuWrData = 0, dmaAddr = 0, dmaWrData = 0, xferOffset = 0, rdData;
  logic [15:0] stCpuAddr, stDmaAddr, stCpuData, stDmaData, controller_status_zero, last_ram_offset;
  logic [7:0] manualTrigErr = 0, chanReqIn = 0, periphStopInIdle = 0;
  logic [7:0] blockDone = 0, blockIntEn = 0;
  logic [7:0] chanReqOut, audioRxBufSel, chanIrq, pingpong_buffer_flag;
  int numErrors = 0, samplesChecked = 0;
  dwcs_write_collision dut (.ref_clk, .arst_n, .cpuWrEn, .cpuRdEn, .cpuIsPeriph, .cpuAddr,
    .cpuWrData, .dmaWrEn, .dmaRdEn, .dmaIsPeriph, .dmaChan, .dmaAddr, .dmaWrData, .stCpuWrEn,
    .stDmaWrEn, .stCpuAddr, .stDmaAddr, .stCpuData, .stDmaData, .errStatusClear, .manualTrigErr,
    .controller_status_zero, .faultTrapReq, .chanReqIn, .sleepMode, .idleMode, .periphStopInIdle,
    .chanReqOut, .audioReq, .audio_buffer_length, .audioChanZero, .audioChanOne, .audioRxBufSel,
    .blockDone, .blockIntEn, .chanIrq, .cpuWake, .xferDone, .xferChan, .xferOffset, .xferBufOne,
    .last_channel_field, .last_ram_offset, .pingpong_buffer_flag);
  dwcs_ram_model ram (.ref_clk, .cpuWe(stCpuWrEn), .cpuAddr(stCpuAddr), .cpuData(stCpuData),
    .dmaWe(stDmaWrEn), .dmaAddr(stDmaAddr), .dmaData(stDmaData), .rdAddr(16'h0003), .rdData);
  // Free-running clock
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      numErrors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic endSim();
    $display("compares %0d mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One shared-path cycle; flags are registered by the next falling edge
  task automatic wr(input logic cw, cp, dp, input logic [15:0] a, b, cd, dd, input logic [2:0] ch);
    @(negedge ref_clk);
    {cpuWrEn, dmaWrEn, cpuIsPeriph, dmaIsPeriph, dmaChan} = {cw, 1'b1, cp, dp, ch};
    {cpuAddr, dmaAddr, cpuWrData, dmaWrData} = {a, b, cd, dd};
    @(negedge ref_clk);
    {cpuWrEn, dmaWrEn} = 2'b00;
  endtask
  task automatic clr();
    @(negedge ref_clk);
    errStatusClear = 1;
    @(negedge ref_clk);
    errStatusClear = 0;
  endtask
  // Watchdog far beyond the 27 cycles of the sequence
  initial begin
    #20000;
    numErrors++;
    endSim();
  end
  initial begin
    repeat (5) @(negedge ref_clk);
    arst_n = 1;
    chanReqIn = 8'hff;
    wr(1, 0, 0, 16'h0003, 16'h0003, 16'haaaa, 16'h5555, 3'h1);
    chk(controller_status_zero, 16'h0002);
    chk({15'h0, faultTrapReq}, 16'h0001);
    chk({8'h0, chanReqOut}, 16'h00fd);
    @(negedge ref_clk);
    chk(rdData, 16'haaaa);
    clr();
    chk(controller_status_zero, 16'h0000);
    chk({15'h0, faultTrapReq}, 16'h0000);
    wr(1, 1, 1, 16'h0010, 16'h0010, 16'h1111, 16'h2222, 3'h0);
    chk(controller_status_zero, 16'h0100);
    clr();
    $display("collision tests done");
    cpuRdEn = 1;
    wr(0, 0, 0, 16'h0003, 16'h0003, 16'h0000, 16'h7777, 3'h2);
    chk(rdData, 16'haaaa);
    cpuRdEn = 0;
    chk(controller_status_zero, 16'h0000);
    wr(1, 0, 1, 16'h0004, 16'h0004, 16'h0001, 16'h0002, 3'h2);
    chk({15'h0, stDmaWrEn}, 16'h0001);
    chk(controller_status_zero, 16'h0000);
    chk(rdData, 16'h7777);
    @(negedge ref_clk);
    manualTrigErr = 8'h08;
    @(negedge ref_clk);
    manualTrigErr = 8'h00;
    chk(controller_status_zero, 16'h0808);
    clr();
    $display("read and manual tests done");
    // No block is in flight when sleep starts
    sleepMode = 1;
    #1 chk({8'h0, chanReqOut}, 16'h0000);
    @(negedge ref_clk);
    {sleepMode, idleMode, periphStopInIdle, blockIntEn} = {2'b01, 8'h0f, 8'hff};
    #1 chk({8'h0, chanReqOut}, 16'h00f0);
    @(negedge ref_clk);
    blockDone = 8'h10;
    @(negedge ref_clk);
    blockDone = 8'h00;
    chk({7'h0, cpuWake, chanIrq}, 16'h0110);
    {idleMode, chanReqIn} = {1'b0, 8'h00};
    {audio_buffer_length, audioChanZero, audioChanOne} = 8'h55;
    audioReq = 1;
    #1 chk({8'h0, chanReqOut}, 16'h0024);
    @(negedge ref_clk);
    {audioReq, xferDone, xferChan, xferOffset, xferBufOne} = {2'b01, 3'h6, 16'h1234, 1'b1};
    @(negedge ref_clk);
    xferDone = 0;
    chk({12'h0, last_channel_field}, 16'h0006);
    chk(last_ram_offset, 16'h1234);
    chk({8'h0, pingpong_buffer_flag}, 16'h0040);
    chk({8'h0, audioRxBufSel}, 16'h0020);
    $display("power, audio and debug tests done");
    endSim();
  end
endmodule
